// *** hdl/pkim_pkg.sv ***
// Notes on behaviour
// - Bank-1 TX accepted interrupt set, cleared with request.
// - Bank-0 TX accepted interrupt cleared with request bit1.
// - CRC error or post-delimiter loss raises CRC interrupt.
// - RX complete interrupt set, cleared with receive-complete flag.
// - TX complete interrupt set, cleared with transmit-done flag.
// - Status bits clear on zero only, ignore mask.
// - PLL unlock during transmit or receive sets interrupt.
// - Auto-ack ready interrupt only while auto-ack enabled.
// - Transmit request flag sets when data write completes.
// - Transmit-done flag reads one once transmission completes.
// - Receive-complete flag holds until host writes zero.
// - CRC flag: one good, overwritten, cleared by zero.
// - Clearing CRC flag leaves CRC error interrupts set.
// - Receive indication register needs core clock enable.
// - Sources reported only when mask bit is one.
// - Sixteen channel-enable bits, all enabled after reset.
// - Interrupt pin held low while unmasked source pending.
package pkim_pkg;
  // Register offsets on the device register port.
  localparam logic [7:0] PKIM_OFS_STATUS_THREE = 8'h26;
  localparam logic [7:0] PKIM_OFS_STATUS_FOUR = 8'h27;
  localparam logic [7:0] PKIM_OFS_TX_REQ = 8'h28;
  localparam logic [7:0] PKIM_OFS_RX_IND = 8'h29;
  localparam logic [7:0] PKIM_OFS_MASK_ONE = 8'h2a;
  localparam logic [7:0] PKIM_OFS_MASK_TWO = 8'h2b;
  localparam logic [7:0] PKIM_OFS_MASK_THREE = 8'h2c;
  localparam logic [7:0] PKIM_OFS_MASK_FOUR = 8'h2d;
  localparam logic [7:0] PKIM_OFS_CH_LOW = 8'h2e;
  localparam logic [7:0] PKIM_OFS_CH_HIGH = 8'h2f;

  // Field positions in the request/confirm and indication registers.
  localparam int PKIM_BIT_BANK1_HI = 5;
  localparam int PKIM_BIT_BANK1_LO = 4;
  localparam int PKIM_BIT_BANK0_HI = 1;
  localparam int PKIM_BIT_BANK0_LO = 0;

  // Field positions in status group three.
  localparam int PKIM_G3_TXACC1 = 7;
  localparam int PKIM_G3_TXACC0 = 6;
  localparam int PKIM_G3_CRC1 = 5;
  localparam int PKIM_G3_CRC0 = 4;
  localparam int PKIM_G3_RXD1 = 3;
  localparam int PKIM_G3_RXD0 = 2;
  localparam int PKIM_G3_TXD1 = 1;
  localparam int PKIM_G3_TXD0 = 0;

  // Field positions in status group four.
  localparam int PKIM_G4_PLL = 1;
  localparam int PKIM_G4_ACK = 0;

  // Reset values.
  localparam logic [7:0] PKIM_RST_MASK_ONE = 8'hff;
  localparam logic [7:0] PKIM_RST_MASK_TWO = 8'hff;
  localparam logic [7:0] PKIM_RST_MASK_THREE = 8'hff;
  localparam logic [7:0] PKIM_RST_MASK_FOUR = 8'h03;
  localparam logic [7:0] PKIM_RST_CH = 8'hff;
  localparam logic [7:0] PKIM_RST_ZERO = 8'h00;

  // One register access from the serial interface decoder.
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pkim_reg_req_t;

  // Event pulses from the FIFO engines and RF state machine, bit 1 is bank 1.
  typedef struct packed {
    logic [1:0] tx_stored;
    logic [1:0] tx_done;
    logic [1:0] rx_done;
    logic [1:0] crc_good;
    logic [1:0] rx_lost;
    logic pll_unlock;
    logic trx_active;
    logic ack_ready;
  } pkim_events_t;
endpackage

// *** hdl/pkim_sticky.sv ***
`timescale 1ns/10ps
`default_nettype none
// Sticky flags that hardware sets and software clears by writing zero.
module pkim_sticky import pkim_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] set,
  input wire logic write_en,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] hw_clear,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] next_q;

  // A set in the same cycle as a clear wins, so no event is lost.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_comb begin
      next_q[i] = set[i] | (q[i] & ~((write_en & ~wdata[i]) | hw_clear[i]));
    end
  end

  // Writing a one leaves the flag as it was.
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// *** hdl/pkim_irq_block.sv ***
`timescale 1ns/10ps
`default_nettype none
module pkim_irq_block import pkim_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire pkim_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic core_clock_enable,
  input wire logic auto_ack_enable,
  input wire pkim_events_t events,
  input wire logic [5:0] irq_status_group_one,
  input wire logic [7:0] irq_status_group_two,
  output logic irq_out_n,
  output logic [1:0] tx_request,
  output logic [15:0] channel_enable
);
  // Everything this module holds besides the sticky flag banks.
  typedef struct packed {
    logic [7:0] mask_one;
    logic [7:0] mask_two;
    logic [7:0] mask_three;
    logic [7:0] mask_four;
    logic [7:0] ch_low;
    logic [7:0] ch_high;
    logic [1:0] crc_ok;
    logic [7:0] rdata;
    logic irq_n;
  } pkim_state_t;

  pkim_state_t state;
  pkim_state_t next_state;
  logic [7:0] wdata;
  logic hit_g3;
  logic hit_g4;
  logic hit_req;
  logic hit_ind;
  logic wr_g3;
  logic wr_g4;
  logic wr_req;
  logic wr_ind;
  logic [3:0] req_set;
  logic [3:0] req_wbits;
  logic [3:0] req_hwclr;
  logic [3:0] req_q;
  logic [1:0] ind_set;
  logic [1:0] ind_wbits;
  logic [1:0] ind_q;
  logic [1:0] crc_err;
  logic [7:0] g3_set;
  logic [7:0] g3_hwclr;
  logic [7:0] g3_q;
  logic [1:0] g4_set;
  logic [1:0] g4_q;
  logic pending;
  logic [7:0] read_value;

  // Address decode; the indication register is locked while the core clock is off.
  assign wdata = reg_req.wdata;
  assign hit_g3 = (reg_req.addr == PKIM_OFS_STATUS_THREE);
  assign hit_g4 = (reg_req.addr == PKIM_OFS_STATUS_FOUR);
  assign hit_req = (reg_req.addr == PKIM_OFS_TX_REQ);
  assign hit_ind = (reg_req.addr == PKIM_OFS_RX_IND) && core_clock_enable;
  assign wr_g3 = reg_req.write && hit_g3;
  assign wr_g4 = reg_req.write && hit_g4;
  assign wr_req = reg_req.write && hit_req;
  assign wr_ind = reg_req.write && hit_ind;

  // Request/confirm flags: [3] request 1, [2] done 1, [1] request 0, [0] done 0.
  // A write of ones cannot set these, software only ever clears them.
  assign req_set = {events.tx_stored[1], events.tx_done[1], events.tx_stored[0], events.tx_done[0]};
  assign req_wbits = {wdata[PKIM_BIT_BANK1_HI], wdata[PKIM_BIT_BANK1_LO],
                      wdata[PKIM_BIT_BANK0_HI], wdata[PKIM_BIT_BANK0_LO]};
  // Fresh transmit data means the bank is not yet sent, so the done flag drops.
  assign req_hwclr = {1'b0, events.tx_stored[1], 1'b0, events.tx_stored[0]};

  pkim_sticky #(.WIDTH(4)) u_req (
    .clock(clock),
    .reset(reset),
    .set(req_set),
    .write_en(wr_req),
    .wdata(req_wbits),
    .hw_clear(req_hwclr),
    .q(req_q)
  );

  // Receive-complete flags survive FIFO read-out and clear only on a zero write.
  assign ind_set = events.rx_done;
  assign ind_wbits = {wdata[PKIM_BIT_BANK1_HI], wdata[PKIM_BIT_BANK0_HI]};

  pkim_sticky #(.WIDTH(2)) u_ind (
    .clock(clock),
    .reset(reset),
    .set(ind_set),
    .write_en(wr_ind),
    .wdata(ind_wbits),
    .hw_clear(2'b00),
    .q(ind_q)
  );

  // A bad CRC on completion or a reception lost after the delimiter both count.
  assign crc_err = (events.rx_done & ~events.crc_good) | events.rx_lost;

  // Group three sources; status records events whatever the masks say.
  assign g3_set[PKIM_G3_TXACC1] = events.tx_stored[1];
  assign g3_set[PKIM_G3_TXACC0] = events.tx_stored[0];
  assign g3_set[PKIM_G3_CRC1] = crc_err[1];
  assign g3_set[PKIM_G3_CRC0] = crc_err[0];
  assign g3_set[PKIM_G3_RXD1] = events.rx_done[1];
  assign g3_set[PKIM_G3_RXD0] = events.rx_done[0];
  assign g3_set[PKIM_G3_TXD1] = events.tx_done[1];
  assign g3_set[PKIM_G3_TXD0] = events.tx_done[0];

  // Zero writes to the handshake flags clear the matching interrupt too.
  // The CRC interrupts have no such link and must be cleared on their own.
  assign g3_hwclr[PKIM_G3_TXACC1] = wr_req && !wdata[PKIM_BIT_BANK1_HI];
  assign g3_hwclr[PKIM_G3_TXACC0] = wr_req && !wdata[PKIM_BIT_BANK0_HI];
  assign g3_hwclr[PKIM_G3_CRC1] = 1'b0;
  assign g3_hwclr[PKIM_G3_CRC0] = 1'b0;
  assign g3_hwclr[PKIM_G3_RXD1] = wr_ind && !wdata[PKIM_BIT_BANK1_HI];
  assign g3_hwclr[PKIM_G3_RXD0] = wr_ind && !wdata[PKIM_BIT_BANK0_HI];
  assign g3_hwclr[PKIM_G3_TXD1] = wr_req && !wdata[PKIM_BIT_BANK1_LO];
  assign g3_hwclr[PKIM_G3_TXD0] = wr_req && !wdata[PKIM_BIT_BANK0_LO];

  pkim_sticky #(.WIDTH(8)) u_g3 (
    .clock(clock),
    .reset(reset),
    .set(g3_set),
    .write_en(wr_g3),
    .wdata(wdata),
    .hw_clear(g3_hwclr),
    .q(g3_q)
  );

  // Group four: PLL unlock counts only in a transmit or receive state.
  assign g4_set[PKIM_G4_PLL] = events.pll_unlock && events.trx_active;
  assign g4_set[PKIM_G4_ACK] = events.ack_ready && auto_ack_enable;

  pkim_sticky #(.WIDTH(2)) u_g4 (
    .clock(clock),
    .reset(reset),
    .set(g4_set),
    .write_en(wr_g4),
    .wdata(wdata[1:0]),
    .hw_clear(2'b00),
    .q(g4_q)
  );

  // Each source is reported only where its mask bit is one.
  assign pending = |(irq_status_group_one & state.mask_one[5:0])
                 | |(irq_status_group_two & state.mask_two)
                 | |(g3_q & state.mask_three)
                 | |(g4_q & state.mask_four[1:0]);

  // Read multiplexer; reserved bits and unmapped offsets read as zero.
  always_comb begin
    read_value = PKIM_RST_ZERO;
    case (reg_req.addr)
      PKIM_OFS_STATUS_THREE: begin
        read_value = g3_q;
      end
      PKIM_OFS_STATUS_FOUR: begin
        read_value = {6'b00_0000, g4_q};
      end
      PKIM_OFS_TX_REQ: begin
        read_value[PKIM_BIT_BANK1_HI] = req_q[3];
        read_value[PKIM_BIT_BANK1_LO] = req_q[2];
        read_value[PKIM_BIT_BANK0_HI] = req_q[1];
        read_value[PKIM_BIT_BANK0_LO] = req_q[0];
      end
      PKIM_OFS_RX_IND: begin
        if (core_clock_enable) begin
          read_value[PKIM_BIT_BANK1_HI] = ind_q[1];
          read_value[PKIM_BIT_BANK1_LO] = state.crc_ok[1];
          read_value[PKIM_BIT_BANK0_HI] = ind_q[0];
          read_value[PKIM_BIT_BANK0_LO] = state.crc_ok[0];
        end
      end
      PKIM_OFS_MASK_ONE: begin
        read_value = state.mask_one;
      end
      PKIM_OFS_MASK_TWO: begin
        read_value = state.mask_two;
      end
      PKIM_OFS_MASK_THREE: begin
        read_value = state.mask_three;
      end
      PKIM_OFS_MASK_FOUR: begin
        read_value = state.mask_four;
      end
      PKIM_OFS_CH_LOW: begin
        read_value = state.ch_low;
      end
      PKIM_OFS_CH_HIGH: begin
        read_value = state.ch_high;
      end
      default: begin
        read_value = PKIM_RST_ZERO;
      end
    endcase
  end

  // Next-state logic for masks, channel enables, CRC results and the pin.
  always_comb begin
    next_state = state;
    if (reg_req.write) begin
      case (reg_req.addr)
        PKIM_OFS_MASK_ONE: begin
          next_state.mask_one = wdata;
        end
        PKIM_OFS_MASK_TWO: begin
          next_state.mask_two = wdata;
        end
        PKIM_OFS_MASK_THREE: begin
          next_state.mask_three = wdata;
        end
        PKIM_OFS_MASK_FOUR: begin
          next_state.mask_four = wdata;
        end
        PKIM_OFS_CH_LOW: begin
          next_state.ch_low = wdata;
        end
        PKIM_OFS_CH_HIGH: begin
          next_state.ch_high = wdata;
        end
        default: begin
          next_state.mask_one = state.mask_one;
        end
      endcase
    end
    // A zero write clears a CRC result; a new packet result overrides it.
    if (wr_ind && !wdata[PKIM_BIT_BANK1_LO]) begin
      next_state.crc_ok[1] = 1'b0;
    end
    if (wr_ind && !wdata[PKIM_BIT_BANK0_LO]) begin
      next_state.crc_ok[0] = 1'b0;
    end
    for (int b = 0; b < 2; b++) begin
      if (events.rx_done[b]) begin
        next_state.crc_ok[b] = events.crc_good[b];
      end else if (events.rx_lost[b]) begin
        next_state.crc_ok[b] = 1'b0;
      end
    end
    if (reg_req.read) begin
      next_state.rdata = read_value;
    end
    // The pin is recomputed each clock and stays low while anything is pending.
    next_state.irq_n = !pending;
  end

  // State register with its power-on defaults.
  always_ff @(posedge clock) begin
    if (reset) begin
      state.mask_one <= PKIM_RST_MASK_ONE;
      state.mask_two <= PKIM_RST_MASK_TWO;
      state.mask_three <= PKIM_RST_MASK_THREE;
      state.mask_four <= PKIM_RST_MASK_FOUR;
      state.ch_low <= PKIM_RST_CH;
      state.ch_high <= PKIM_RST_CH;
      state.crc_ok <= 2'b00;
      state.rdata <= PKIM_RST_ZERO;
      state.irq_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign irq_out_n = state.irq_n;
  assign tx_request = {req_q[3], req_q[1]};
  assign channel_enable = {state.ch_high, state.ch_low};

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_crc1_zero_write;
    wr_ind && !wdata[PKIM_BIT_BANK1_LO] && !wr_g3;
  endsequence

  sequence s_no_crc1_event;
    !events.rx_done[1] && !events.rx_lost[1];
  endsequence

  a_irq_pin_low: assert property (pending |=> !irq_out_n)
    else $error("Interrupt pin not low with an unmasked source pending.");
  a_irq_pin_quiet: assert property (!pending |=> irq_out_n)
    else $error("Interrupt pin low with no unmasked source.");
  a_masked_source: assert property (g3_q[PKIM_G3_TXD0] && !state.mask_three[PKIM_G3_TXD0]
    && (g3_q & state.mask_three) == 8'h00 && (g4_q & state.mask_four[1:0]) == 2'b00
    && (irq_status_group_one & state.mask_one[5:0]) == 6'b00_0000
    && (irq_status_group_two & state.mask_two) == 8'h00 |=> irq_out_n)
    else $error("Masked source drove the interrupt pin.");
  a_txreq_set: assert property (events.tx_stored[1] |=> tx_request[1] && g3_q[PKIM_G3_TXACC1])
    else $error("Bank 1 transmit request or accepted interrupt not set.");
  a_txacc1_clear: assert property (wr_req && !wdata[PKIM_BIT_BANK1_HI] && !events.tx_stored[1]
    |=> !g3_q[PKIM_G3_TXACC1] && !tx_request[1])
    else $error("Bank 1 accepted interrupt survived request clear.");
  a_txacc0_clear: assert property (wr_req && !wdata[PKIM_BIT_BANK0_HI] && !events.tx_stored[0]
    |=> !g3_q[PKIM_G3_TXACC0])
    else $error("Bank 0 accepted interrupt survived request clear.");
  a_crc_lost: assert property (events.rx_lost[0] |=> g3_q[PKIM_G3_CRC0] && !state.crc_ok[0])
    else $error("Lost reception did not raise the CRC interrupt.");
  a_rx_complete: assert property (events.rx_done[1] |=> g3_q[PKIM_G3_RXD1] && ind_q[1])
    else $error("Receive complete not flagged for bank 1.");
  a_tx_complete: assert property (events.tx_done[0] |=> g3_q[PKIM_G3_TXD0] && req_q[0])
    else $error("Transmit complete not flagged for bank 0.");
  a_one_no_clear: assert property (wr_g3 |=> (($past(g3_q) & $past(wdata)) & ~g3_q) == 8'h00)
    else $error("Writing one cleared a status bit.");
  a_pll_unlock: assert property (events.pll_unlock && events.trx_active |=> g4_q[PKIM_G4_PLL])
    else $error("PLL unlock in a transmit or receive state not recorded.");
  a_ack_gated: assert property (!auto_ack_enable && !g4_q[PKIM_G4_ACK] |=> !g4_q[PKIM_G4_ACK])
    else $error("Auto-ack ready set while auto-ack disabled.");
  a_rx_flag_hold: assert property (ind_q[0] && !(wr_ind && !wdata[PKIM_BIT_BANK0_HI]) |=> ind_q[0])
    else $error("Receive complete flag dropped without a zero write.");
  a_crc_int_kept: assert property (g3_q[PKIM_G3_CRC1] ##0 s_crc1_zero_write ##0 s_no_crc1_event
    |=> g3_q[PKIM_G3_CRC1] && !state.crc_ok[1])
    else $error("CRC interrupt cleared along with the CRC result.");
  a_ind_locked: assert property (!core_clock_enable && ind_q[0] && state.crc_ok[0]
    && !events.rx_done[0] && !events.rx_lost[0] |=> ind_q[0] && state.crc_ok[0])
    else $error("Indication register changed while the core clock was off.");
  a_crc_result: assert property (events.rx_done[0] |=> state.crc_ok[0] == $past(events.crc_good[0]))
    else $error("CRC result flag did not take the new packet result.");
endmodule
`default_nettype wire

// *** verification/pkim_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Behavioural host controller that reaches the block through its register port.
module pkim_host_model import pkim_pkg::*; (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output var pkim_reg_req_t reg_req
);
  // The port idles from time zero so nothing is taken while reset is high.
  initial begin
    reg_req = '0;
  end

  // One write held for exactly one edge; clearing uses zeros on the chosen bits and ones elsewhere.
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    reg_req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(posedge clock);
    #1;
    reg_req = '0;
  endtask

  // One read; the data is taken just after the edge that accepted the strobe.
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clock);
    #1;
    reg_req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clock);
    #1;
    reg_req = '0;
    data = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** verification/pkim_irq_block_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the packet interrupt status and mask block.
module pkim_irq_block_bench import pkim_pkg::*; ;
  logic clock;
  logic reset;
  pkim_reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic core_clock_enable;
  logic auto_ack_enable;
  pkim_events_t events;
  logic [5:0] grp_one;
  logic [7:0] grp_two;
  logic irq_out_n;
  logic [1:0] tx_request;
  logic [15:0] channel_enable;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] reset_exp [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff};

  pkim_irq_block u_dut (.clock(clock), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .core_clock_enable(core_clock_enable), .auto_ack_enable(auto_ack_enable), .events(events),
    .irq_status_group_one(grp_one), .irq_status_group_two(grp_two), .irq_out_n(irq_out_n),
    .tx_request(tx_request), .channel_enable(channel_enable));

  pkim_host_model u_host (.clock(clock), .reg_rdata(reg_rdata), .reg_req(reg_req));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare with case inequality so an unknown never passes.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read(addr, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    u_host.write(addr, data);
  endtask

  // The pin is registered behind the flags, so two edges pass before it is looked at.
  task automatic irq(input logic exp);
    repeat (2) @(posedge clock);
    #1;
    chk({15'h0000, irq_out_n}, {15'h0000, exp});
  endtask

  // One-cycle event pulse, then one more edge so flags and pin have settled.
  task automatic pulse(input pkim_events_t e);
    @(posedge clock);
    #1;
    events = e;
    @(posedge clock);
    #1;
    events = '0;
    @(posedge clock);
    #1;
  endtask

  task automatic do_reset();
    reset = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    reset = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    print_verdict();
  end

  // Main sequence: reset values, flag set and clear paths, masking and a second reset.
  initial begin
    reset = 1'b1;
    events = '0;
    core_clock_enable = 1'b1;
    auto_ack_enable = 1'b0;
    grp_one = 6'h00;
    grp_two = 8'h00;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      rd(8'h26 + 8'(i), reset_exp[i]);
    end
    chk(channel_enable, 16'hffff);
    chk({15'h0000, irq_out_n}, 16'h0001);
    rd(8'h30, 8'h00);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    wr(8'h2e, 8'h5a);
    wr(8'h2f, 8'ha5);
    chk(channel_enable, 16'ha55a);
    rd(8'h2f, 8'ha5);
    // Transmit requests on both banks and their accepted interrupts.
    pulse('{tx_stored: 2'b10, default: '0});
    chk({14'h0000, tx_request}, 16'h0002);
    rd(8'h28, 8'h20);
    rd(8'h26, 8'h80);
    irq(1'b0);
    wr(8'h28, 8'hff);
    rd(8'h28, 8'h20);
    wr(8'h28, 8'hdf);
    rd(8'h26, 8'h00);
    irq(1'b1);
    pulse('{tx_stored: 2'b01, default: '0});
    chk({14'h0000, tx_request}, 16'h0001);
    rd(8'h26, 8'h40);
    wr(8'h28, 8'hfd);
    rd(8'h26, 8'h00);
    chk({14'h0000, tx_request}, 16'h0000);
    // Transmit completion on both banks.
    pulse('{tx_done: 2'b11, default: '0});
    rd(8'h28, 8'h11);
    rd(8'h26, 8'h03);
    wr(8'h28, 8'hef);
    rd(8'h26, 8'h01);
    wr(8'h28, 8'hfe);
    rd(8'h26, 8'h00);
    // Reception with good then bad CRC, overwrite, and flag clear leaving the error.
    pulse('{rx_done: 2'b10, crc_good: 2'b10, default: '0});
    rd(8'h29, 8'h30);
    rd(8'h26, 8'h08);
    rd(8'h29, 8'h30);
    wr(8'h29, 8'hdf);
    rd(8'h26, 8'h00);
    pulse('{rx_done: 2'b10, default: '0});
    rd(8'h29, 8'h20);
    rd(8'h26, 8'h28);
    pulse('{rx_done: 2'b10, crc_good: 2'b10, default: '0});
    rd(8'h29, 8'h30);
    wr(8'h29, 8'hef);
    rd(8'h29, 8'h20);
    rd(8'h26, 8'h28);
    wr(8'h26, 8'hff);
    rd(8'h26, 8'h28);
    wr(8'h26, 8'hd7);
    rd(8'h26, 8'h00);
    wr(8'h29, 8'h00);
    pulse('{rx_lost: 2'b01, default: '0});
    rd(8'h26, 8'h10);
    wr(8'h26, 8'hef);
    // Indication register gated by the core clock enable.
    pulse('{rx_done: 2'b01, crc_good: 2'b01, default: '0});
    core_clock_enable = 1'b0;
    rd(8'h29, 8'h00);
    wr(8'h29, 8'h00);
    core_clock_enable = 1'b1;
    rd(8'h29, 8'h03);
    wr(8'h29, 8'h00);
    rd(8'h26, 8'h00);
    // Group four sources and their qualifiers.
    pulse('{pll_unlock: 1'b1, default: '0});
    rd(8'h27, 8'h00);
    pulse('{pll_unlock: 1'b1, trx_active: 1'b1, default: '0});
    rd(8'h27, 8'h02);
    pulse('{ack_ready: 1'b1, default: '0});
    rd(8'h27, 8'h02);
    auto_ack_enable = 1'b1;
    pulse('{ack_ready: 1'b1, default: '0});
    rd(8'h27, 8'h03);
    wr(8'h27, 8'hfd);
    rd(8'h27, 8'h01);
    wr(8'h27, 8'h00);
    // Masking per group; status keeps recording while masked.
    wr(8'h2d, 8'h01);
    pulse('{pll_unlock: 1'b1, trx_active: 1'b1, default: '0});
    irq(1'b1);
    rd(8'h27, 8'h02);
    wr(8'h2d, 8'h03);
    irq(1'b0);
    wr(8'h27, 8'h00);
    irq(1'b1);
    grp_one = 6'h20;
    irq(1'b0);
    wr(8'h2a, 8'hdf);
    irq(1'b1);
    grp_two = 8'h80;
    irq(1'b0);
    wr(8'h2b, 8'h7f);
    irq(1'b1);
    pulse('{tx_done: 2'b01, default: '0});
    wr(8'h2c, 8'hfe);
    irq(1'b1);
    rd(8'h2c, 8'hfe);
    wr(8'h2c, 8'hff);
    irq(1'b0);
    // A second reset in mid-run restores every default.
    do_reset();
    chk(channel_enable, 16'hffff);
    chk({15'h0000, irq_out_n}, 16'h0001);
    rd(8'h2a, 8'hff);
    rd(8'h2d, 8'h03);
    rd(8'h26, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
